// >>> design/temp_limit_registers.sv
// Purpose: Pointer-selected limit registers behind a two-wire slave, with open-drain alert.
// Assumes: Bus clock no faster than about a tenth of the core clock; result from same clock.
// Notes: Configuration pointer reads zero and ignores writes; conversion lives elsewhere.
`timescale 1ns/1ps
// Overview of operation
// - The low-limit register sits at pointer 2 and resets to 4B00h, which is 75 degrees.
// - Low-limit bits 15 to 8 hold the upper limit byte in one-degree steps.
// - Low-limit bits 7 to 4 hold the fraction nibble in sixteenth-degree steps.
// - The high-limit register sits at pointer 3 and resets to 5000h, which is 80 degrees.
// - High-limit bits 15 to 8 hold the upper limit byte in one-degree steps.
// - High-limit bits 7 to 4 hold the fraction nibble in sixteenth-degree steps.
// - Three strap pins select one of eight slave addresses.
// - Alert is pulled only while the result lies beyond the limits, so lines can be shared.
// - Data and alert pins only pull low or release and never drive high.
// - The two low bits of the pointer byte select the register used by later transfers.
// - The result uses the same left-aligned format as the limits so they compare directly.
module temp_limit_registers
   import temp_limit_pkg::*;
#(
   parameter logic [3:0] BUS_ADDR_HI = 4'h9
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Address straps
   input wire logic addr_strap_0_in,
   input wire logic addr_strap_1_in,
   input wire logic addr_strap_2_in,
   // Conversion result and alert pin
   input wire limit_t result_in,
   output logic alert_out,
   output logic alert_oe_out
);
   logic [PIN_COUNT-1:0] pins;
   logic scl_q, sda_q, scl_rise, scl_fall, start_seen, stop_seen, beyond;
   logic [6:0] own_addr;
   bus_state_t st_q, st_d, nxt_q, nxt_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, wbyte_q, wbyte_d;
   logic [1:0] ptr_q, ptr_d;
   logic bidx_q, bidx_d, sda_oe_q, sda_oe_d, alert_oe_q, alert_oe_d;
   limit_t low_q, low_d, high_q, high_d;

   pin_sync #(.WIDTH(PIN_COUNT), .RESET_VAL(PIN_SYNC_RESET)) u_pin_sync (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .async_in({addr_strap_2_in, addr_strap_1_in, addr_strap_0_in, sda_in, scl_in}),
      .sync_out(pins)
   );

   // A limit or result word as seen on the bus, reserved nibble forced to zero.
   function automatic logic [15:0] to_word(input limit_t v);
      to_word = {v, RESERVED_BITS};
   endfunction

   function automatic logic [7:0] read_byte(input logic [1:0] ptr, input logic second,
                                            input limit_t res, input limit_t lo,
                                            input limit_t hi);
      logic [15:0] w;
      unique case (ptr)
         PTR_RESULT: w = to_word(res);
         PTR_CONFIG: w = 16'h0000;
         PTR_LOW: w = to_word(lo);
         PTR_HIGH: w = to_word(hi);
      endcase
      read_byte = second ? w[7:0] : w[15:8];
   endfunction

   assign scl_rise = pins[PIN_SCL] && !scl_q;
   assign scl_fall = !pins[PIN_SCL] && scl_q;
   assign start_seen = pins[PIN_SCL] && scl_q && sda_q && !pins[PIN_SDA];
   assign stop_seen = pins[PIN_SCL] && scl_q && !sda_q && pins[PIN_SDA];
   assign own_addr = {BUS_ADDR_HI, pins[PIN_STRAP_LSB+2:PIN_STRAP_LSB]};
   // Signed compare works because both sides share one left-aligned format.
   assign beyond = ($signed(result_in) < $signed(low_q)) ||
                   ($signed(result_in) > $signed(high_q));

   always_comb begin
      st_d = st_q;
      nxt_d = nxt_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      wbyte_d = wbyte_q;
      ptr_d = ptr_q;
      bidx_d = bidx_q;
      sda_oe_d = sda_oe_q;
      low_d = low_q;
      high_d = high_q;
      alert_oe_d = beyond;
      if (start_seen) begin
         st_d = ST_ADDR;
         cnt_d = BIT_COUNT_RESET;
         sda_oe_d = 1'b0;
      end else if (stop_seen) begin
         st_d = ST_IDLE;
         sda_oe_d = 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               sda_oe_d = 1'b0;
            end
            ST_ADDR, ST_PTR, ST_WDATA: begin
               if (scl_rise && cnt_q != BITS_PER_BYTE) begin
                  sh_d = {sh_q[6:0], pins[PIN_SDA]};
                  cnt_d = cnt_q + 4'h1;
               end
               if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                  cnt_d = BIT_COUNT_RESET;
                  st_d = ST_ACK;
                  sda_oe_d = 1'b1;
                  if (st_q == ST_ADDR) begin
                     bidx_d = 1'b0;
                     nxt_d = sh_q[0] ? ST_RDATA : ST_PTR;
                     if (sh_q[7:1] != own_addr) begin
                        st_d = ST_IDLE;
                        sda_oe_d = 1'b0;
                     end
                  end else if (st_q == ST_PTR) begin
                     ptr_d = sh_q[1:0];
                     nxt_d = ST_WDATA;
                  end else begin
                     nxt_d = ST_WDATA;
                     bidx_d = !bidx_q;
                     if (!bidx_q) begin
                        wbyte_d = sh_q;
                     end else if (ptr_q == PTR_LOW) begin
                        low_d = '{upper_byte: wbyte_q, fraction_nibble: sh_q[7:4]};
                     end else if (ptr_q == PTR_HIGH) begin
                        high_d = '{upper_byte: wbyte_q, fraction_nibble: sh_q[7:4]};
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  st_d = nxt_q;
                  sda_oe_d = 1'b0;
                  if (nxt_q == ST_RDATA) begin
                     sh_d = read_byte(ptr_q, bidx_q, result_in, low_q, high_q);
                     sda_oe_d = !sh_d[7];
                  end
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
               end
               if (scl_fall) begin
                  if (cnt_q == BITS_PER_BYTE) begin
                     cnt_d = BIT_COUNT_RESET;
                     sda_oe_d = 1'b0;
                     st_d = ST_RACK;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     sda_oe_d = !sh_q[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise && pins[PIN_SDA]) begin
                  st_d = ST_IDLE;
               end else if (scl_fall) begin
                  bidx_d = !bidx_q;
                  sh_d = read_byte(ptr_q, !bidx_q, result_in, low_q, high_q);
                  sda_oe_d = !sh_d[7];
                  st_d = ST_RDATA;
               end
            end
            default: begin
               st_d = ST_IDLE;
               sda_oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         st_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         cnt_q <= BIT_COUNT_RESET;
         sh_q <= BYTE_RESET;
         wbyte_q <= BYTE_RESET;
         ptr_q <= PTR_RESET;
         bidx_q <= 1'b0;
         sda_oe_q <= 1'b0;
         alert_oe_q <= 1'b0;
         low_q <= LOW_RESET[FIELD_MSB:FIELD_LSB];
         high_q <= HIGH_RESET[FIELD_MSB:FIELD_LSB];
      end else begin
         scl_q <= pins[PIN_SCL];
         sda_q <= pins[PIN_SDA];
         st_q <= st_d;
         nxt_q <= nxt_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         wbyte_q <= wbyte_d;
         ptr_q <= ptr_d;
         bidx_q <= bidx_d;
         sda_oe_q <= sda_oe_d;
         alert_oe_q <= alert_oe_d;
         low_q <= low_d;
         high_q <= high_d;
      end
   end

   // Open-drain pins: the level is always low, the enable decides whether it pulls.
   assign sda_out = 1'b0;
   assign alert_out = 1'b0;
   assign sda_oe_out = sda_oe_q;
   assign alert_oe_out = alert_oe_q;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   logic wcommit;
   assign wcommit = st_q == ST_WDATA && scl_fall && cnt_q == BITS_PER_BYTE && bidx_q &&
                    !start_seen && !stop_seen;

   property p_low_reset;
      $rose(rst_n_in) |-> to_word(low_q) == LOW_RESET;
   endproperty
   a_low_reset: assert property (p_low_reset) else $error("low limit reset value wrong");
   property p_high_reset;
      $rose(rst_n_in) |-> to_word(high_q) == HIGH_RESET;
   endproperty
   a_high_reset: assert property (p_high_reset) else $error("high limit reset value wrong");
   property p_low_write;
      wcommit && ptr_q == PTR_LOW |=> low_q.upper_byte == $past(wbyte_q) &&
         low_q.fraction_nibble == $past(sh_q[7:4]) && $stable(high_q);
   endproperty
   a_low_write: assert property (p_low_write) else $error("low limit write wrong");
   property p_high_write;
      wcommit && ptr_q == PTR_HIGH |=> high_q.upper_byte == $past(wbyte_q) &&
         high_q.fraction_nibble == $past(sh_q[7:4]) && $stable(low_q);
   endproperty
   a_high_write: assert property (p_high_write) else $error("high limit write wrong");
   // Checked at load time, since shifting pads the low end with zeros and would hide a fault.
   property p_reserved_zero;
      ptr_q[1] && st_q == ST_RDATA && bidx_q && cnt_q == BIT_COUNT_RESET |->
         sh_q[3:0] == RESERVED_BITS;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");
   property p_addr_miss;
      st_q == ST_ADDR && scl_fall && cnt_q == BITS_PER_BYTE && sh_q[7:1] != own_addr &&
         !start_seen && !stop_seen |=> st_q == ST_IDLE ##1 !sda_oe_q;
   endproperty
   a_addr_miss: assert property (p_addr_miss) else $error("acked a foreign address");
   property p_pointer;
      st_q == ST_PTR && scl_fall && cnt_q == BITS_PER_BYTE && !start_seen && !stop_seen
         |=> ptr_q == $past(sh_q[1:0]) && st_q == ST_ACK && sda_oe_q;
   endproperty
   a_pointer: assert property (p_pointer) else $error("pointer not taken");
   property p_alert;
      beyond |=> alert_oe_q;
   endproperty
   a_alert: assert property (p_alert) else $error("alert not pulled beyond limits");
   property p_alert_clear;
      !beyond |=> !alert_oe_q;
   endproperty
   a_alert_clear: assert property (p_alert_clear) else $error("alert pulled within limits");
   property p_open_drain;
      !sda_out && !alert_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("pin driven high");

   c_write_low: cover property (wcommit && ptr_q == PTR_LOW);
   c_read_byte: cover property (st_q == ST_RDATA ##[1:1000] st_q == ST_RACK);
   c_alert: cover property (!alert_oe_q ##1 alert_oe_q);
endmodule // temp_limit_registers

// >>> design/temp_limit_pkg.sv
// Purpose: Shared constants, carriers and states for the limit register bank.
// Assumes: Two-wire bus sampled on the 20 MHz core clock.
// Notes: Limit and result words are 12-bit two's complement, left aligned.
package temp_limit_pkg;

   // Twelve significant bits: one degree per upper-byte step, 1/16 degree per nibble step.
   typedef struct packed {
      logic [7:0] upper_byte;
      logic [3:0] fraction_nibble;
   } limit_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_PTR,
      ST_WDATA,
      ST_ACK,
      ST_RDATA,
      ST_RACK
   } bus_state_t;

   localparam logic [1:0] PTR_RESULT = 2'h0;
   localparam logic [1:0] PTR_CONFIG = 2'h1;
   localparam logic [1:0] PTR_LOW = 2'h2;
   localparam logic [1:0] PTR_HIGH = 2'h3;
   localparam logic [1:0] PTR_RESET = 2'h0;
   localparam logic [15:0] LOW_RESET = 16'h4B00;
   localparam logic [15:0] HIGH_RESET = 16'h5000;
   localparam logic [3:0] RESERVED_BITS = 4'h0;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam int FIELD_MSB = 15;
   localparam int FIELD_LSB = 4;
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_STRAP_LSB = 2;
   localparam int PIN_COUNT = 5;
   localparam logic [4:0] PIN_SYNC_RESET = 5'h03;

endpackage

// >>> design/pin_sync.sv
// Purpose: Two-stage synchroniser for pins that arrive from outside the core clock.
// Assumes: Pins are slow compared with the core clock.
// Notes: Only the second stage is visible to the rest of the design.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Pins and their synchronised copies
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stable_q;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         meta_q <= RESET_VAL;
         stable_q <= RESET_VAL;
      end else begin
         meta_q <= async_in;
         stable_q <= meta_q;
      end
   end

   assign sync_out = stable_q;
endmodule // pin_sync

// >>> verif/bus_host_model.sv
// Purpose: Host controller model that pulls the clock and data lines low, open-drain.
// Assumes: Eight core clocks high and ten low per bus bit, above the five-clock minimum phase.
// Notes: A released line rises through the bench pull-up and never keeps a stale value.
`timescale 1ns/1ps
module bus_host_model (
   // Clock and bus level
   input wire logic core_clk_in,
   input wire logic sda_line_in,
   // Open-drain pulls
   output logic scl_low_out,
   output logic sda_low_out
);
   initial begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task automatic start();
      sda_low_out <= 1'b0;
      hold(8);
      scl_low_out <= 1'b0;
      hold(8);
      sda_low_out <= 1'b1;
      hold(8);
      scl_low_out <= 1'b1;
      hold(2);
   endtask
   task automatic stop();
      sda_low_out <= 1'b1;
      hold(8);
      scl_low_out <= 1'b0;
      hold(8);
      sda_low_out <= 1'b0;
      hold(8);
   endtask
   // Data moves two clocks after the clock falls, so no change can pass for a start or stop.
   task automatic bit_io(input logic b, output logic r);
      sda_low_out <= !b;
      hold(8);
      scl_low_out <= 1'b0;
      hold(4);
      r = sda_line_in;
      hold(4);
      scl_low_out <= 1'b1;
      hold(2);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic nb, output logic [7:0] rx,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(nb, ack);
   endtask
endmodule // bus_host_model

// >>> verif/tb_top.sv
// Purpose: Self-checking bench comparing the limit bank with an integer model.
// Assumes: Host model timing of eight core clocks high and ten low per bus bit.
// Notes: Alert is checked only with the bus idle, while the result is held still.
`timescale 1ns/1ps
module tb_top;
   import temp_limit_pkg::*;
   localparam logic [3:0] ADDR_HI = 4'h9;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [2:0] strap;
   limit_t result;
   logic sda_out;
   logic sda_oe_out;
   logic alert_out;
   logic alert_oe_out;
   logic scl_low;
   logic sda_low;
   logic [7:0] rx;
   logic ack;
   logic [1:0] ptr_m;
   int low_m;
   int high_m;
   int n_errors = 0;
   int checks = 0;
   int seed = 32'ha51d;
   wire logic scl_line = !scl_low;
   wire logic sda_line = !(sda_low || sda_oe_out);
   logic [11:0] pts [6] = '{12'h4B0, 12'h4AF, 12'h500, 12'h501, 12'hFFF, 12'h7FF};
   always #25 core_clk_in = ~core_clk_in;
   temp_limit_registers #(.BUS_ADDR_HI(ADDR_HI)) i_temp_limit_registers (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_line),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .addr_strap_0_in(strap[0]), .addr_strap_1_in(strap[1]), .addr_strap_2_in(strap[2]),
      .result_in(result), .alert_out(alert_out), .alert_oe_out(alert_oe_out));
   bus_host_model i_bus_host_model (.core_clk_in(core_clk_in), .sda_line_in(sda_line),
      .scl_low_out(scl_low), .sda_low_out(sda_low));
   function automatic int sx(input logic [11:0] v);
      return v[11] ? int'(v) - 4096 : int'(v);
   endfunction
   function automatic logic [15:0] model_rd();
      case (ptr_m)
         PTR_LOW: return low_m[15:0];
         PTR_HIGH: return high_m[15:0];
         PTR_CONFIG: return 16'h0000;
         default: return {result, 4'h0};
      endcase
   endfunction
   task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_bit(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic addr(input logic [6:0] a, input logic rd, input logic hit);
      i_bus_host_model.start();
      i_bus_host_model.xfer({a, rd}, 1'b1, rx, ack);
      cmp_bit("addr_ack", !hit, ack);
   endtask
   task automatic wr_reg(input logic [1:0] p, input logic [15:0] v, input logic data);
      addr({ADDR_HI, strap}, 1'b0, 1'b1);
      i_bus_host_model.xfer({6'h00, p}, 1'b1, rx, ack);
      cmp_bit("ptr_ack", 1'b0, ack);
      ptr_m = p;
      if (data) begin
         i_bus_host_model.xfer(v[15:8], 1'b1, rx, ack);
         cmp_bit("msb_ack", 1'b0, ack);
         i_bus_host_model.xfer(v[7:0], 1'b1, rx, ack);
         cmp_bit("lsb_ack", 1'b0, ack);
         // The reserved nibble is never stored, so the model drops it on entry.
         if (p == PTR_LOW) low_m = v & 16'hFFF0;
         if (p == PTR_HIGH) high_m = v & 16'hFFF0;
      end
      i_bus_host_model.stop();
   endtask
   task automatic rd_reg();
      logic [7:0] hi;
      addr({ADDR_HI, strap}, 1'b1, 1'b1);
      i_bus_host_model.xfer(8'hFF, 1'b0, hi, ack);
      i_bus_host_model.xfer(8'hFF, 1'b1, rx, ack);
      i_bus_host_model.stop();
      cmp_word("read_word", model_rd(), {hi, rx});
   endtask
   task automatic chk_alert(input logic [11:0] r);
      logic e;
      result <= r;
      i_bus_host_model.hold(4);
      #1;
      e = sx(r) < sx(low_m[15:4]) || sx(r) > sx(high_m[15:4]);
      cmp_bit("alert_pull", e, alert_oe_out);
      cmp_bit("alert_level", 1'b0, alert_out);
      cmp_bit("data_level", 1'b0, sda_out);
      i_bus_host_model.hold(1);
   endtask
   task automatic report_and_stop();
      if (n_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge core_clk_in);
      n_errors++;
      report_and_stop();
   end
   initial begin
      strap = 3'h0;
      result = '0;
      low_m = 16'h4B00;
      high_m = 16'h5000;
      ptr_m = PTR_RESET;
      repeat (12) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      result <= 12'h321;
      i_bus_host_model.hold(6);
      rd_reg();
      wr_reg(PTR_LOW, 16'h0000, 1'b0);
      rd_reg();
      wr_reg(PTR_HIGH, 16'h0000, 1'b0);
      rd_reg();
      rd_reg();
      for (int i = 0; i < 8; i++) begin
         wr_reg(i[1:0], 16'($random(seed)), 1'b1);
         rd_reg();
      end
      wr_reg(PTR_LOW, 16'h4B00, 1'b1);
      wr_reg(PTR_HIGH, 16'h5000, 1'b1);
      foreach (pts[i]) chk_alert(pts[i]);
      for (int i = 0; i < 8; i++) chk_alert(12'($random(seed)));
      wr_reg(PTR_RESULT, 16'h0000, 1'b0);
      rd_reg();
      for (int s = 0; s < 8; s++) begin
         strap <= s[2:0];
         i_bus_host_model.hold(6);
         addr({ADDR_HI, strap}, 1'b0, 1'b1);
         i_bus_host_model.stop();
         addr({ADDR_HI, strap ^ 3'h5}, 1'b0, 1'b0);
         i_bus_host_model.stop();
      end
      rst_n_in <= 1'b0;
      i_bus_host_model.hold(4);
      rst_n_in <= 1'b1;
      low_m = 16'h4B00;
      high_m = 16'h5000;
      ptr_m = PTR_RESET;
      i_bus_host_model.hold(6);
      rd_reg();
      wr_reg(PTR_HIGH, 16'h0000, 1'b0);
      rd_reg();
      report_and_stop();
   end
endmodule // tb_top
